/* File: rtl/iec_counter.sv */
module iec_counter (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_pin_a,
  input wire logic i_pin_b,
  input wire logic i_pin_c,
  input wire logic i_pin_gate,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_count1,
  output logic [31:0] o_count2,
  output logic [31:0] o_latch
);
  import iec_pkg::*;

  // pin order in the vectors: {gate, c, b, a}
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic [7:0] ctrl;
    logic [15:0] feature;
    logic latched;
    logic [31:0] count1;
    logic [31:0] count2;
    logic [31:0] latch;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } iec_state_t;

  // one map for both directions so reads and writes cannot drift apart
  typedef enum logic [2:0] {
    IEC_REG_NONE,
    IEC_REG_CTRL,
    IEC_REG_FEATURE,
    IEC_REG_COUNT1,
    IEC_REG_LATCH,
    IEC_REG_COUNT2,
    IEC_REG_STATUS
  } iec_reg_t;

  function automatic iec_reg_t iec_decode(input logic [7:0] ad);
    iec_reg_t sel;
    sel = IEC_REG_NONE;
    if (ad == IEC_OFS_CTRL) begin
      sel = IEC_REG_CTRL;
    end else if (ad == IEC_OFS_FEATURE) begin
      sel = IEC_REG_FEATURE;
    end else if (ad == IEC_OFS_COUNT1) begin
      sel = IEC_REG_COUNT1;
    end else if (ad == IEC_OFS_LATCH) begin
      sel = IEC_REG_LATCH;
    end else if (ad == IEC_OFS_COUNT2) begin
      sel = IEC_REG_COUNT2;
    end else if (ad == IEC_OFS_STATUS) begin
      sel = IEC_REG_STATUS;
    end
    return sel;
  endfunction

  iec_state_t s_q;
  iec_state_t s_d;

  iec_quad_if q1 ();
  iec_quad_if q2 ();

  logic counter_mode;
  logic dual;
  logic a_now, b_now, c_now, g_now;
  logic c_rise, g_rise, g_fall, a_rise;
  logic cnt_inc, cnt_dec;
  logic latch_hit;
  logic addr_phase;
  logic [7:0] addr;
  logic wr_latched_clr;
  iec_reg_t wr_sel;
  iec_reg_t rd_sel;

  assign counter_mode = s_q.feature[IEC_BIT_MODE];
  assign dual = s_q.ctrl[IEC_BIT_DUAL];
  assign a_now = s_q.sync2[0];
  assign b_now = s_q.sync2[1];
  assign c_now = s_q.sync2[2];
  assign g_now = s_q.sync2[3];
  assign a_rise = a_now & ~s_q.prev[0];
  assign c_rise = c_now & ~s_q.prev[2];
  assign g_rise = g_now & ~s_q.prev[3];
  assign g_fall = ~g_now & s_q.prev[3];

  // in dual mode pin c carries A2 and the gate pin carries B2
  assign q1.a = a_now;
  assign q1.b = b_now;
  assign q2.a = c_now;
  assign q2.b = g_now;

  iec_quad_decoder u_dec1 (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .q(q1.decoder)
  );

  iec_quad_decoder u_dec2 (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .q(q2.decoder)
  );

  always_comb begin
    if (counter_mode) begin
      cnt_inc = a_rise & c_now & ~b_now;
      cnt_dec = a_rise & c_now & b_now;
    end else begin
      cnt_inc = q1.inc;
      cnt_dec = q1.dec;
    end
  end

  // no latch sources in counter mode or on the two-encoder variant
  always_comb begin
    latch_hit = 1'b0;
    if (!counter_mode && !dual) begin
      latch_hit = (s_q.ctrl[IEC_BIT_ZERO_LATCH] & c_rise)
                | (s_q.ctrl[IEC_BIT_RISE_LATCH] & g_rise)
                | (s_q.ctrl[IEC_BIT_FALL_LATCH] & g_fall);
    end
  end

  assign addr_phase = i_hsel & i_hready
                    & ((i_htrans == IEC_HTRANS_NONSEQ) | (i_htrans == IEC_HTRANS_SEQ));
  assign addr = i_haddr[7:0];
  assign wr_sel = iec_decode(s_q.wr_addr);
  assign rd_sel = iec_decode(addr);
  assign wr_latched_clr = s_q.wr_pend & (wr_sel == IEC_REG_STATUS)
                        & i_hwdata[IEC_BIT_LATCHED];

  always_comb begin
    s_d = s_q;
    s_d.sync1 = {i_pin_gate, i_pin_c, i_pin_b, i_pin_a};
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    s_d.count1 = iec_step(s_q.count1, cnt_inc, cnt_dec);
    s_d.count2 = (dual && !counter_mode) ? iec_step(s_q.count2, q2.inc, q2.dec) : s_q.count2;
    // latch takes the count as it stood before this cycle's step
    if (latch_hit) begin
      s_d.latch = s_q.count1;
    end
    // set wins over a clear in the same cycle
    if (wr_latched_clr) begin
      s_d.latched = 1'b0;
    end
    if (latch_hit) begin
      s_d.latched = 1'b1;
    end
    s_d.wr_pend = 1'b0;
    if (s_q.wr_pend) begin
      if (wr_sel == IEC_REG_CTRL) begin
        s_d.ctrl = i_hwdata[7:0];
      end else if (wr_sel == IEC_REG_FEATURE) begin
        s_d.feature = i_hwdata[15:0];
      end
    end
    if (addr_phase) begin
      s_d.wr_pend = i_hwrite;
      s_d.wr_addr = addr;
      s_d.rdata = 32'h0000_0000;
      if (!i_hwrite) begin
        if (rd_sel == IEC_REG_CTRL) begin
          s_d.rdata = {24'h00_0000, s_q.ctrl};
        end else if (rd_sel == IEC_REG_FEATURE) begin
          s_d.rdata = {16'h0000, s_q.feature};
        end else if (rd_sel == IEC_REG_COUNT1) begin
          s_d.rdata = s_q.count1;
        end else if (rd_sel == IEC_REG_LATCH) begin
          s_d.rdata = s_q.latch;
        end else if (rd_sel == IEC_REG_COUNT2) begin
          s_d.rdata = s_q.count2;
        end else if (rd_sel == IEC_REG_STATUS) begin
          s_d.rdata = {27'h0, s_q.sync2, s_q.latched};
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.ctrl <= IEC_CTRL_RESET;
      s_q.feature <= IEC_FEATURE_RESET;
      s_q.count1 <= IEC_COUNT_RESET;
      s_q.count2 <= IEC_COUNT_RESET;
      s_q.latch <= IEC_COUNT_RESET;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  // stall the bus while the block is frozen
  assign o_hreadyout = i_clk_en;
  assign o_hresp = 1'b0;
  assign o_hrdata = s_q.rdata;
  assign o_count1 = s_q.count1;
  assign o_count2 = s_q.count2;
  assign o_latch = s_q.latch;
endmodule

/* File: rtl/iec_pkg.sv */
package iec_pkg;
  localparam logic [7:0] IEC_OFS_CTRL = 8'h00;
  localparam logic [7:0] IEC_OFS_FEATURE = 8'h04;
  localparam logic [7:0] IEC_OFS_COUNT1 = 8'h08;
  localparam logic [7:0] IEC_OFS_LATCH = 8'h0C;
  localparam logic [7:0] IEC_OFS_COUNT2 = 8'h10;
  localparam logic [7:0] IEC_OFS_STATUS = 8'h14;

  localparam int IEC_BIT_ZERO_LATCH = 0;
  localparam int IEC_BIT_RISE_LATCH = 3;
  localparam int IEC_BIT_FALL_LATCH = 4;
  localparam int IEC_BIT_DUAL = 5;
  localparam int IEC_BIT_MODE = 15;
  localparam int IEC_BIT_LATCHED = 0;

  localparam logic [7:0] IEC_CTRL_RESET = 8'h00;
  localparam logic [15:0] IEC_FEATURE_RESET = 16'h0000;
  localparam logic [31:0] IEC_COUNT_RESET = 32'h0000_0000;

  localparam logic [1:0] IEC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] IEC_HTRANS_SEQ = 2'h3;

  // one count step; inc and dec never both high
  function automatic logic [31:0] iec_step(input logic [31:0] cnt, input logic inc,
                                           input logic dec);
    if (inc) begin
      return cnt + 32'h0000_0001;
    end else if (dec) begin
      return cnt - 32'h0000_0001;
    end
    return cnt;
  endfunction
endpackage

/* File: rtl/iec_quad_decoder.sv */
module iec_quad_decoder (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  iec_quad_if.decoder q
);
  import iec_pkg::*;

  typedef struct packed {
    logic [1:0] prev;
  } iec_dec_state_t;

  iec_dec_state_t s_q;
  iec_dec_state_t s_d;
  logic [1:0] cur;

  assign cur = {q.a, q.b};

  // forward order 00-01-11-10 counts up, reverse counts down; double steps dropped
  always_comb begin
    s_d = s_q;
    s_d.prev = cur;
    q.inc = 1'b0;
    q.dec = 1'b0;
    case ({s_q.prev, cur})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: q.inc = i_clk_en;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: q.dec = i_clk_en;
      default: ;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s_q <= '0;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end
endmodule

/* File: rtl/iec_quad_if.sv */
interface iec_quad_if;
  logic a;
  logic b;
  logic inc;
  logic dec;
  modport decoder (input a, input b, output inc, output dec);
  modport owner (output a, output b, input inc, input dec);
endinterface

/* File: tb/iec_counter_assertions.sv */
module iec_counter_assertions (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_pin_a,
  input wire logic i_pin_b,
  input wire logic i_pin_c,
  input wire logic i_pin_gate,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_count1,
  input wire logic [31:0] o_count2,
  input wire logic [31:0] o_latch
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // three edges from pin to count
  sequence s_ab;
    $past(i_pin_a, 3) != $past(i_pin_a, 4) || $past(i_pin_b, 3) != $past(i_pin_b, 4);
  endsequence
  sequence s_cg;
    $past(i_pin_c, 3) != $past(i_pin_c, 4) || $past(i_pin_gate, 3) != $past(i_pin_gate, 4);
  endsequence
  AST_CNT1_CAUSE: assert property (!$stable(o_count1) |-> s_ab)
    else $error("count1 moved alone");
  AST_CNT1_STEP: assert property (!$stable(o_count1) |->
    (o_count1 - $past(o_count1)) inside {32'h1, 32'hFFFF_FFFF}) else $error("count1 jump");
  AST_LATCH_CAUSE: assert property (!$stable(o_latch) |-> s_cg)
    else $error("latch moved alone");
  AST_LATCH_VALUE: assert property (!$stable(o_latch) |-> o_latch == $past(o_count1))
    else $error("latch value");
  AST_CNT2_CAUSE: assert property (!$stable(o_count2) |-> s_cg)
    else $error("count2 moved alone");
  AST_CNT2_STEP: assert property (!$stable(o_count2) |->
    (o_count2 - $past(o_count2)) inside {32'h1, 32'hFFFF_FFFF}) else $error("count2 jump");
  AST_FREEZE: assert property (!$past(i_clk_en) |->
    $stable(o_count1) && $stable(o_count2) && $stable(o_latch)) else $error("moved while frozen");
  AST_READY: assert property (o_hreadyout == i_clk_en && !o_hresp)
    else $error("bus answer");
  AST_RESET: assert property (disable iff (1'b0) i_rst && i_clk_en |=>
    o_count1 == 32'h0 && o_count2 == 32'h0 && o_latch == 32'h0) else $error("reset");
endmodule
bind iec_counter iec_counter_assertions i_iec_counter_assertions (.i_clock, .i_rst,
  .i_clk_en, .i_pin_a, .i_pin_b, .i_pin_c, .i_pin_gate, .o_hreadyout, .o_hresp,
  .o_count1, .o_count2, .o_latch);

/* File: tb/iec_enc_model.sv */
module iec_enc_model (
  input wire logic i_clock,
  input wire logic i_up,
  input wire logic i_dn,
  output logic o_a,
  output logic o_b
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] ph_q = 2'h0;
  always_ff @(posedge i_clock) begin
    ph_q <= ph_q + {i_dn, i_up ^ i_dn};
  end
  // gray order keeps one track moving per step
  assign o_a = ph_q[1];
  assign o_b = ph_q[1] ^ ph_q[0];
endmodule

/* File: tb/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import iec_pkg::*;
  logic i_clock = 0, i_rst = 1, hsel = 0, hwrite = 0, en = 1;
  logic [1:0] htrans = 2'h0;
  logic [3:0] mv = 4'h0;
  logic [31:0] haddr = 0, hwdata = 0, c1 = 0, lat = 0, q;
  wire logic a, b, c, g, rdy, resp;
  wire logic [31:0] rdata, cnt1, cnt2, latch;
  int err_total = 0, num_checks = 0, cyc = 0;
  `define CHK(x, y) begin num_checks++; if ((x) !== (y)) begin err_total++; \
    $display("mismatch at %0t got %h exp %h", $time, x, y); end end
  initial forever #12.5 i_clock = ~i_clock;
  iec_counter i_iec_counter (.i_clock, .i_rst, .i_clk_en(en), .i_pin_a(a), .i_pin_b(b),
    .i_pin_c(c), .i_pin_gate(g), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy),
    .o_hrdata(rdata), .o_hreadyout(rdy), .o_hresp(resp), .o_count1(cnt1),
    .o_count2(cnt2), .o_latch(latch));
  iec_enc_model i_iec_enc_model (.i_clock, .i_up(mv[0]), .i_dn(mv[1]), .o_a(a), .o_b(b));
  iec_enc_model i_iec_enc_model_2 (.i_clock, .i_up(mv[2]), .i_dn(mv[3]), .o_a(c), .o_b(g));
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_clock);
    hsel <= 1;
    htrans <= IEC_HTRANS_NONSEQ;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do @(posedge i_clock); while (!rdy);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clock); while (!rdy);
    q = rdata;
  endtask
  // i: 0 up1, 1 down1, 2 up2, 3 down2
  task automatic step(input int i, input int n);
    repeat (n) begin
      mv[i] <= 1;
      @(posedge i_clock);
      mv[i] <= 0;
      repeat (5) @(posedge i_clock);
    end
  endtask
  task automatic t_regs;
    bus(0, IEC_OFS_FEATURE, 0);
    `CHK(q, 32'h0)
    bus(1, IEC_OFS_CTRL, 32'hFFFF_FFFF);
    bus(0, IEC_OFS_CTRL, 0);
    `CHK(q, 32'h0000_00FF)
    bus(0, 8'h40, 0);
    `CHK(q, 32'h0)
    $display("regs done");
  endtask
  task automatic t_latch;
    int eb[4] = '{IEC_BIT_RISE_LATCH, IEC_BIT_ZERO_LATCH, IEC_BIT_FALL_LATCH, 8};
    for (int m = 0; m < 4; m++) begin
      bus(1, IEC_OFS_CTRL, 32'h1 << eb[m]);
      for (int k = 0; k < 4; k++) begin
        step(0, 1);
        c1++;
        step(2, 1);
        if (k == m && m < 3) lat = c1;
        `CHK(latch, lat)
      end
    end
    step(1, 3);
    c1 -= 3;
    bus(0, IEC_OFS_COUNT1, 0);
    `CHK(q, c1)
    bus(0, IEC_OFS_STATUS, 0);
    `CHK(q, 32'h5)
    bus(1, IEC_OFS_STATUS, 32'h1);
    bus(0, IEC_OFS_STATUS, 0);
    `CHK(q, 32'h4)
    `CHK(cnt2, 32'h0)
    $display("latch done");
  endtask
  task automatic t_dual;
    bus(1, IEC_OFS_CTRL, 32'h39);
    step(2, 5);
    `CHK(cnt2, 32'h5)
    `CHK(latch, lat)
    `CHK(cnt1, c1)
    step(3, 5);
    `CHK(cnt2, 32'h0)
    $display("dual done");
  endtask
  task automatic t_cnt;
    bus(1, IEC_OFS_FEATURE, 32'h1 << IEC_BIT_MODE);
    step(1, 4);
    `CHK(cnt1, c1)
    step(2, 2);
    `CHK(latch, lat)
    step(1, 8);
    c1 += 2;
    `CHK(cnt1, c1)
    step(0, 4);
    c1--;
    `CHK(cnt1, c1)
    $display("count done");
  endtask
  // bus must stall while frozen and finish once released
  task automatic t_freeze;
    en <= 1'b0;
    @(posedge i_clock);
    fork
      bus(0, IEC_OFS_COUNT1, 0);
      begin
        repeat (3) @(posedge i_clock);
        `CHK(rdy, 1'b0)
        en <= 1'b1;
      end
    join
    `CHK(q, c1)
    `CHK(resp, 1'b0)
    $display("freeze done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge i_clock);
    i_rst <= 0;
    t_regs();
    t_latch();
    t_dual();
    t_cnt();
    t_freeze();
    wrap_up();
  end
endmodule
